//--- rtl/crxe_crc.sv
// Serial CAN CRC register of selectable width and polynomial
`timescale 1ns/1ps
`default_nettype none
module crxe_crc #(
	parameter int             W    = 15,
	parameter logic [W-1:0]   POLY = '0
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Bit feed
	input  wire logic         restart,
	input  wire logic         bit_en,
	input  wire logic         bit_val,
	// Result
	output logic [W-1:0]      crc
);
	logic fb;
	assign fb = bit_val ^ crc[W-1];

	// Only the bits offered by bit_en enter; no stuff count is folded
	always_ff @(posedge aclk) begin
		if (!aresetn || restart) begin
			crc <= '0;
		end else if (bit_en) begin
			crc <= {crc[W-2:0], 1'b0} ^ (fb ? POLY : '0);
		end
	end
endmodule : crxe_crc
`default_nettype wire

//--- rtl/crxe_pkg.sv
// Constants, register map and types for the CAN receive exception and RAM fault block
// Function
// - FD CRC is computed without any stuff-bit count; classical CRC is unchanged.
// - Receive error counter and error-passive flag are readable by software.
// - Error passive with counter at 127 may flag a RAM failure at frame end.
// - RAM failure flag with its enable set raises the host interrupt.
// - Unless disabled, recessive FDF then recessive res enters bus integration.
// - Bus integration ends after 11 consecutive recessive bits.
// - After an exception, recessive counting starts only after one dominant bit.
// - Store not granted in time drops that message at the next frame, sets failure flag.
// - After such a failure the following stored element may be inconsistent.
// - A programmable RAM watchdog sets its flag when the arbiter answers too late.
// - Clearing the init control bit also enters the integration phase.
package crxe_pkg;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_ERR    = 8'h04;
	localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CL = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
	localparam logic [7:0] ADDR_WDOG   = 8'h14;
	localparam logic [7:0] ADDR_STATE  = 8'h18;
	localparam int CTRL_INIT  = 0;
	localparam int CTRL_PXHD  = 1;
	localparam int IRQ_MRAF   = 0;
	localparam int IRQ_WDI    = 1;
	localparam int IRQ_PXE    = 2;
	localparam int IRQ_N      = 3;
	localparam logic [1:0] CTRL_RESET = 2'h1;
	localparam logic [7:0] WDOG_RESET = 8'h00;
	localparam logic [3:0] INTEG_BITS = 4'hb;
	localparam logic [8:0] REC_MAX_ACTIVE = 9'h07f;
	localparam logic [8:0] REC_CEIL       = 9'h0ff;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [14:0] CRC15_POLY = 15'h4599;
	localparam logic [16:0] CRC17_POLY = 17'h1685b;
	localparam logic [20:0] CRC21_POLY = 21'h102899;
	typedef enum logic [1:0] {ST_INIT, ST_WAIT_DOM, ST_INTEG, ST_ACTIVE} crxe_state_t;
endpackage : crxe_pkg

//--- rtl/crxe_top.sv
// Receive exception handling, bus integration and Message RAM fault logic
`timescale 1ns/1ps
`default_nettype none
module crxe_top import crxe_pkg::*; #(
	parameter int WDOG_W        = 8,
	parameter bit SPURIOUS_MRAF = 1'b1
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Sampled CAN bits, 1 is recessive
	input  wire logic        bit_strobe,
	input  wire logic        rx_bit,
	input  wire logic        crc_bit_en,
	input  wire logic        crc_restart,
	// Frame decoder events
	input  wire logic        fdf_res_recessive,
	input  wire logic        frame_start,
	input  wire logic        frame_end,
	// Error counter events
	input  wire logic        rec_inc1,
	input  wire logic        rec_inc8,
	input  wire logic        rec_dec,
	input  wire logic        tec_passive,
	// Rx handler and RAM arbiter
	input  wire logic        store_req,
	output logic             ram_req,
	input  wire logic        ram_gnt,
	output logic             msg_drop,
	// Status
	output logic             bus_integrating,
	output logic             bus_active,
	output logic [14:0]      crc15,
	output logic [16:0]      crc17,
	output logic [20:0]      crc21,
	output logic             irq
);
	crxe_state_t       state;
	logic [3:0]        rcnt;
	logic [1:0]        ctrl;
	logic [8:0]        rec;
	logic [IRQ_N-1:0]  irq_status;
	logic [IRQ_N-1:0]  irq_enable;
	logic [IRQ_N-1:0]  irq_set;
	logic [IRQ_N-1:0]  irq_clr;
	logic [WDOG_W-1:0] wdog_delay;
	logic [WDOG_W-1:0] wd_cnt;
	logic              wd_fired;
	logic              fail_pend;
	logic              suspect;
	logic              in_frame;
	logic              aw_full;
	logic              w_full;
	logic [7:0]        aw_addr;
	logic [31:0]       w_data;
	logic              w_lane0;
	logic              do_wr;
	logic              init_bit;
	logic              pxhd;
	logic              error_passive;
	logic [6:0]        rx_count;
	logic              pxe;
	logic              timeout;
	logic              spurious;
	logic              store_pend_q;

	assign init_bit = ctrl[CTRL_INIT];
	assign pxhd     = ctrl[CTRL_PXHD];
	// Counter is shown saturated at 127; passive state carries the rest
	assign error_passive = (rec > REC_MAX_ACTIVE) || tec_passive;
	assign rx_count      = (rec > REC_MAX_ACTIVE) ? REC_MAX_ACTIVE[6:0] : rec[6:0];

	// ---------------- AXI4-Lite slave ----------------
	assign awready = !aw_full && !bvalid;
	assign wready  = !w_full && !bvalid;
	assign arready = !rvalid;
	assign do_wr   = aw_full && w_full && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			aw_addr <= 8'h00;
		end else if (awvalid && awready) begin
			aw_full <= 1'b1;
			aw_addr <= awaddr;
		end else if (do_wr) begin
			aw_full <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full  <= 1'b0;
			w_data  <= 32'h0000_0000;
			w_lane0 <= 1'b0;
		end else if (wvalid && wready) begin
			w_full  <= 1'b1;
			w_data  <= wdata;
			w_lane0 <= wstrb[0];
		end else if (do_wr) begin
			w_full <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid <= 1'b1;
			unique case (aw_addr)
				ADDR_CTRL, ADDR_ERR, ADDR_IRQ_ST, ADDR_IRQ_CL, ADDR_IRQ_EN, ADDR_WDOG, ADDR_STATE: bresp <= RESP_OKAY;
				default: bresp <= RESP_SLVERR;
			endcase
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// All fields sit in byte lane 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl       <= CTRL_RESET;
			irq_enable <= '0;
			wdog_delay <= WDOG_RESET[WDOG_W-1:0];
		end else if (do_wr && w_lane0) begin
			if (aw_addr == ADDR_CTRL) begin
				ctrl <= w_data[1:0];
			end
			if (aw_addr == ADDR_IRQ_EN) begin
				irq_enable <= w_data[IRQ_N-1:0];
			end
			if (aw_addr == ADDR_WDOG) begin
				wdog_delay <= w_data[WDOG_W-1:0];
			end
		end
	end

	assign irq_clr = (do_wr && w_lane0 && aw_addr == ADDR_IRQ_CL) ? w_data[IRQ_N-1:0] : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rresp  <= RESP_OKAY;
			rdata  <= 32'h0000_0000;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= RESP_OKAY;
			rdata  <= 32'h0000_0000;
			unique case (araddr)
				ADDR_CTRL:   rdata[1:0] <= ctrl;
				ADDR_ERR:    rdata[7:0] <= {error_passive, rx_count};
				ADDR_IRQ_ST: rdata[IRQ_N-1:0] <= irq_status;
				ADDR_IRQ_CL: rdata <= 32'h0000_0000;
				ADDR_IRQ_EN: rdata[IRQ_N-1:0] <= irq_enable;
				ADDR_WDOG:   rdata[WDOG_W-1:0] <= wdog_delay;
				ADDR_STATE:  rdata[5:0] <= {suspect, ram_req, state == ST_ACTIVE, state == ST_WAIT_DOM,
					state == ST_INTEG, state == ST_INIT};
				default:     rresp <= RESP_SLVERR;
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ---------------- Bus integration ----------------
	assign pxe = (state == ST_ACTIVE) && fdf_res_recessive && !pxhd;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_INIT;
			rcnt  <= 4'h0;
		end else if (init_bit) begin
			state <= ST_INIT;
			rcnt  <= 4'h0;
		end else begin
			unique case (state)
				ST_INIT: begin
					state <= ST_INTEG;
					rcnt  <= 4'h0;
				end
				ST_WAIT_DOM: begin
					// Counting waits for a dominant bit first
					if (bit_strobe && !rx_bit) begin
						state <= ST_INTEG;
						rcnt  <= 4'h0;
					end
				end
				ST_INTEG: begin
					if (bit_strobe) begin
						if (!rx_bit) begin
							rcnt <= 4'h0;
						end else if (rcnt == INTEG_BITS - 4'h1) begin
							state <= ST_ACTIVE;
							rcnt  <= 4'h0;
						end else begin
							rcnt <= rcnt + 4'h1;
						end
					end
				end
				ST_ACTIVE: begin
					if (pxe) begin
						state <= ST_WAIT_DOM;
					end
				end
			endcase
		end
	end

	assign bus_integrating = (state == ST_INTEG) || (state == ST_WAIT_DOM);
	assign bus_active      = (state == ST_ACTIVE);

	// ---------------- Receive error counter ----------------
	// Above 127 a good frame drops the counter back to 127
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rec <= 9'h000;
		end else if (rec_dec) begin
			if (rec > REC_MAX_ACTIVE) begin
				rec <= REC_MAX_ACTIVE;
			end else if (rec != 9'h000) begin
				rec <= rec - 9'h001;
			end
		end else if (rec_inc8) begin
			rec <= (rec > REC_CEIL - 9'h008) ? REC_CEIL : rec + 9'h008;
		end else if (rec_inc1 && rec != REC_CEIL) begin
			rec <= rec + 9'h001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_frame <= 1'b0;
		end else if (frame_start) begin
			in_frame <= 1'b1;
		end else if (frame_end) begin
			in_frame <= 1'b0;
		end
	end

	// Kept on purpose so firmware sees the same flag pattern as the silicon
	assign spurious = SPURIOUS_MRAF && in_frame && frame_end && error_passive && rx_count == REC_MAX_ACTIVE[6:0];

	// ---------------- RAM request, watchdog and failure ----------------
	// Only a waiting store requests; a pending failure must not keep the arbiter busy
	assign ram_req = store_pend_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			store_pend_q <= 1'b0;
		end else if (ram_req && ram_gnt) begin
			store_pend_q <= 1'b0;
		end else if (store_req) begin
			store_pend_q <= 1'b1;
		end
	end

	assign timeout = store_pend_q && !ram_gnt && !wd_fired && wdog_delay != '0
		&& wd_cnt == wdog_delay - 1'b1;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wd_cnt   <= '0;
			wd_fired <= 1'b0;
		end else if (!store_pend_q || ram_gnt) begin
			wd_cnt   <= '0;
			wd_fired <= 1'b0;
		end else if (timeout) begin
			wd_fired <= 1'b1;
		end else if (!wd_fired) begin
			wd_cnt <= wd_cnt + 1'b1;
		end
	end

	// Late store is not withdrawn; the message is given up at the next frame
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fail_pend <= 1'b0;
			msg_drop  <= 1'b0;
		end else begin
			msg_drop <= frame_start && fail_pend;
			if (timeout) begin
				fail_pend <= 1'b1;
			end else if (frame_start) begin
				fail_pend <= 1'b0;
			end
		end
	end

	// Next element may be half written; cleared by a store granted in time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			suspect <= 1'b0;
		end else if (frame_start && fail_pend) begin
			suspect <= 1'b1;
		end else if (store_pend_q && ram_gnt && !wd_fired && !fail_pend) begin
			suspect <= 1'b0;
		end
	end

	// ---------------- Interrupts ----------------
	assign irq_set[IRQ_MRAF] = (frame_start && fail_pend) || spurious;
	assign irq_set[IRQ_WDI]  = timeout;
	assign irq_set[IRQ_PXE]  = pxe;

	// A set in the same cycle as its clear wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
		end
	end

	assign irq = |(irq_status & irq_enable);

	// ---------------- CRC units ----------------
	crxe_crc #(.W(15), .POLY(CRC15_POLY)) u_crc15 (.aclk(aclk), .aresetn(aresetn), .restart(crc_restart),
		.bit_en(bit_strobe && crc_bit_en), .bit_val(rx_bit), .crc(crc15));
	crxe_crc #(.W(17), .POLY(CRC17_POLY)) u_crc17 (.aclk(aclk), .aresetn(aresetn), .restart(crc_restart),
		.bit_en(bit_strobe && crc_bit_en), .bit_val(rx_bit), .crc(crc17));
	crxe_crc #(.W(21), .POLY(CRC21_POLY)) u_crc21 (.aclk(aclk), .aresetn(aresetn), .restart(crc_restart),
		.bit_en(bit_strobe && crc_bit_en), .bit_val(rx_bit), .crc(crc21));

	// ---------------- Checks ----------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	integ_exit_a: assert property ($rose(state == ST_ACTIVE) |-> $past(rcnt) == 4'ha && $past(rx_bit))
		else $error("integration left without 11 recessive bits");
	wait_dom_a: assert property (state == ST_WAIT_DOM && !init_bit && !(bit_strobe && !rx_bit)
		|=> state == ST_WAIT_DOM || init_bit)
		else $error("recessive counting started before a dominant bit");
	pxe_enter_a: assert property (pxe && !init_bit |=> state == ST_WAIT_DOM && irq_status[IRQ_PXE])
		else $error("exception did not enter integration");
	pxhd_hold_a: assert property (state == ST_ACTIVE && pxhd && !init_bit |=> state == ST_ACTIVE)
		else $error("exception handled while disabled");
	init_integ_a: assert property (state == ST_INIT && !init_bit |=> state == ST_INTEG || init_bit)
		else $error("init release did not start integration");
	wdog_fire_a: assert property ($rose(ram_req) && !ram_gnt && wdog_delay == 8'h05
		##1 (ram_req && !ram_gnt)[*4] |=> irq_status[IRQ_WDI])
		else $error("watchdog flag missing after delay");
	drop_flag_a: assert property (msg_drop |-> irq_status[IRQ_MRAF] && $past(frame_start) && suspect)
		else $error("message drop without failure flag");
	spur_flag_a: assert property (spurious |=> irq_status[IRQ_MRAF])
		else $error("spurious failure flag not set");
	err_view_a: assert property (rec_inc8 && !rec_dec && rec >= 9'h078 |=> error_passive)
		else $error("error passive not shown");
	irq_out_a: assert property (irq_status[IRQ_MRAF] && irq_enable[IRQ_MRAF] |-> irq)
		else $error("enabled failure flag without interrupt");
	req_hold_a: assert property (ram_req && !ram_gnt |=> ram_req)
		else $error("RAM request withdrawn before grant");

	pxe_back_c: cover property (pxe ##[1:400] state == ST_ACTIVE);
	wdog_c: cover property (timeout ##[1:100] msg_drop);
	spur_c: cover property (spurious);
	clr_set_c: cover property (irq_clr[IRQ_MRAF] && irq_set[IRQ_MRAF]);
endmodule : crxe_top
`default_nettype wire

//--- testbench/crxe_ram_model.sv
// Behavioural RAM arbiter that grants each request after a set wait
`timescale 1ns/1ps
`default_nettype none
module crxe_ram_model (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Arbiter handshake
	input  wire logic       ram_req,
	output logic            ram_gnt,
	// Wait cycles before the grant
	input  wire logic [7:0] delay
);
	logic [7:0] wait_cnt;
	// One-cycle grant, so a stale grant never meets a fresh request
	always_ff @(posedge aclk) begin
		if (!aresetn || !ram_req || ram_gnt) begin
			wait_cnt <= 8'h00;
			ram_gnt  <= 1'b0;
		end else begin
			wait_cnt <= wait_cnt + 8'h01;
			ram_gnt  <= (wait_cnt == delay);
		end
	end
endmodule : crxe_ram_model
`default_nettype wire

//--- testbench/crxe_top_bench.sv
// Self-checking bench for the receive exception and RAM fault block
`timescale 1ns/1ps
`default_nettype none
module crxe_top_bench import crxe_pkg::*;;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr, mdl_delay;
	logic [31:0] wdata, rdata;
	logic        awready, wready, bvalid, arready, rvalid, irq, ram_req, ram_gnt, msg_drop;
	logic [1:0]  bresp, rresp;
	logic        bit_strobe, rx_bit, crc_bit_en, tec_passive, bus_integrating, bus_active;
	logic [6:0]  ev;
	logic [14:0] crc15;
	logic [16:0] crc17;
	logic [20:0] crc21;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	int          n_fail, n_compared;
	integer      seed;
	crxe_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .bit_strobe(bit_strobe), .rx_bit(rx_bit),
		.crc_bit_en(crc_bit_en), .crc_restart(1'b0), .fdf_res_recessive(ev[6]), .frame_start(ev[1]),
		.frame_end(ev[2]), .rec_inc1(ev[3]), .rec_inc8(ev[4]), .rec_dec(ev[5]), .tec_passive(tec_passive),
		.store_req(ev[0]), .ram_req(ram_req), .ram_gnt(ram_gnt), .msg_drop(msg_drop),
		.bus_integrating(bus_integrating), .bus_active(bus_active), .crc15(crc15), .crc17(crc17),
		.crc21(crc21), .irq(irq));
	crxe_ram_model u_ram (.aclk(aclk), .aresetn(aresetn), .ram_req(ram_req), .ram_gnt(ram_gnt),
		.delay(mdl_delay));
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task end_sim;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	task chk(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk
	// Responses are judged at the negedge before the edge that takes them
	always @(negedge aclk) begin
		if (rvalid === 1'b1 && rready === 1'b1)
			chk(rq.size() > 0 && {rresp, rdata} === rq.pop_front(), "read response");
		if (bvalid === 1'b1 && bready === 1'b1)
			chk(bq.size() > 0 && bresp === bq.pop_front(), "write response");
	end
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_t, w_t, b_t;
		bq.push_back(r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(negedge aclk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid && bready;
			@(posedge aclk);
			if (aw_t)
				awvalid <= 1'b0;
			if (w_t)
				wvalid <= 1'b0;
			if (b_t) begin
				bready <= 1'b0;
				return;
			end
		end
		chk(1'b0, "write timeout");
		end_sim();
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		logic ar_t, r_t;
		rq.push_back({r, d});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(negedge aclk);
			ar_t = arvalid && arready;
			r_t = rvalid && rready;
			@(posedge aclk);
			if (ar_t)
				arvalid <= 1'b0;
			if (r_t) begin
				rready <= 1'b0;
				return;
			end
		end
		chk(1'b0, "read timeout");
		end_sim();
	endtask : rd
	task pulse(input int i);
		@(posedge aclk);
		ev[i] <= 1'b1;
		@(posedge aclk);
		ev[i] <= 1'b0;
	endtask : pulse
	task bits(input int n, input logic b);
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			bit_strobe <= 1'b1;
			rx_bit <= b;
			@(posedge aclk);
			bit_strobe <= 1'b0;
		end
		@(negedge aclk);
	endtask : bits
	task wait_gnt;
		@(negedge aclk);
		for (int i = 0; i < 200 && ram_req !== 1'b0; i++)
			@(negedge aclk);
		chk(ram_req === 1'b0, "grant never came");
	endtask : wait_gnt
	function automatic logic [20:0] crc_step(logic [20:0] c, logic b, int w, logic [20:0] p);
		logic top;
		top = b ^ c[w-1];
		c = (c << 1) & ((21'h1 << w) - 21'h1);
		return top ? c ^ p : c;
	endfunction : crc_step
	initial begin
		repeat (20000) @(posedge aclk);
		chk(1'b0, "run timeout");
		end_sim();
	end
	initial begin : main
		logic [20:0] c15, c17, c21;
		logic [31:0] r;
		int          n;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, bit_strobe, tec_passive} = '0;
		{awaddr, araddr, wdata, ev, crc_bit_en} = '0;
		rx_bit = 1'b1;
		mdl_delay = 8'h0c;
		seed = 32'h29cc;
		{c15, c17, c21} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_CTRL, 32'h1);
		rd(ADDR_WDOG, 32'h0);
		rd(ADDR_IRQ_EN, 32'h0);
		rd(ADDR_STATE, 32'h1);
		rd(ADDR_ERR, 32'h0);
		rd(8'h1c, 32'h0, RESP_SLVERR);
		wr(8'h1c, 32'h3, RESP_SLVERR);
		rd(ADDR_CTRL, 32'h1);
		// Random bits into the CRCs while still in init, where the state ignores them
		crc_bit_en <= 1'b1;
		for (int i = 0; i < 24; i++) begin
			r = $random(seed);
			bits(1, r[0]);
			c15 = crc_step(c15, r[0], 15, {6'h0, CRC15_POLY});
			c17 = crc_step(c17, r[0], 17, {4'h0, CRC17_POLY});
			c21 = crc_step(c21, r[0], 21, CRC21_POLY);
		end
		crc_bit_en <= 1'b0;
		chk(crc15 === c15[14:0] && crc17 === c17[16:0] && crc21 === c21, "crc value");
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		rd(ADDR_STATE, 32'h2);
		bits(10, 1'b1);
		bits(1, 1'b0);
		bits(10, 1'b1);
		chk(bus_integrating === 1'b1, "left integration early");
		bits(1, 1'b1);
		chk(bus_active === 1'b1, "no exit after 11 recessive");
		wr(ADDR_IRQ_EN, 32'h4, RESP_OKAY);
		pulse(6);
		@(negedge aclk);
		chk(bus_integrating === 1'b1 && irq === 1'b1, "exception not taken");
		rd(ADDR_STATE, 32'h4);
		bits(15, 1'b1);
		chk(bus_integrating === 1'b1, "counted before a dominant bit");
		bits(1, 1'b0);
		bits(11, 1'b1);
		chk(bus_active === 1'b1, "no exit after exception");
		wr(ADDR_IRQ_CL, 32'h4, RESP_OKAY);
		rd(ADDR_IRQ_ST, 32'h0);
		rd(ADDR_IRQ_CL, 32'h0);
		wr(ADDR_CTRL, 32'h2, RESP_OKAY);
		pulse(6);
		@(negedge aclk);
		chk(bus_active === 1'b1, "exception while disabled");
		wr(ADDR_WDOG, 32'h5, RESP_OKAY);
		wr(ADDR_IRQ_EN, 32'h3, RESP_OKAY);
		pulse(0);
		for (n = 0; n < 100 && irq !== 1'b1; n++)
			@(negedge aclk);
		chk(n == 6, "watchdog timing");
		wait_gnt();
		pulse(1);
		@(negedge aclk);
		chk(msg_drop === 1'b1, "no drop at next frame");
		rd(ADDR_IRQ_ST, 32'h3);
		rd(ADDR_STATE, 32'h28);
		wr(ADDR_IRQ_CL, 32'h3, RESP_OKAY);
		chk(irq === 1'b0, "irq stays after clear");
		mdl_delay <= 8'h02;
		pulse(0);
		wait_gnt();
		rd(ADDR_STATE, 32'h8);
		tec_passive <= 1'b1;
		repeat (15) pulse(4);
		repeat (7) pulse(3);
		rd(ADDR_ERR, 32'hff);
		pulse(1);
		pulse(2);
		@(negedge aclk);
		chk(irq === 1'b1, "no failure interrupt");
		rd(ADDR_IRQ_ST, 32'h1);
		rd(ADDR_ERR, 32'hff);
		wr(ADDR_IRQ_CL, 32'h1, RESP_OKAY);
		rd(ADDR_IRQ_ST, 32'h0);
		tec_passive <= 1'b0;
		pulse(4);
		rd(ADDR_ERR, 32'hff);
		pulse(5);
		rd(ADDR_ERR, 32'h7f);
		repeat (4) @(posedge aclk);
		end_sim();
	end
endmodule : crxe_top_bench
`default_nettype wire
